// ==== hw/mwd_pkg.sv ====
// constants shared by the motion wake detector and its per-axis slice
// assumes a single 10 MHz clock domain and AXI4-Lite register access
package mwd_pkg;

  localparam int AXIS_N  = 3;
  localparam int SMP_W   = 12;
  localparam int DELTA_W = 11;
  localparam int FLD_W   = 6;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;

  // printed offsets are indices; byte address is four times the index
  localparam int IDX_AXIS_CTRL = 'h10;
  localparam int IDX_THR_CTRL  = 'h13;
  localparam int IDX_CFG       = 'h14;
  localparam int IDX_STATUS    = 'h15;
  localparam logic [ADDR_W-1:0] ADDR_AXIS_CTRL = ADDR_W'(IDX_AXIS_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_THR_CTRL  = ADDR_W'(IDX_THR_CTRL * 4);
  localparam logic [ADDR_W-1:0] ADDR_CFG       = ADDR_W'(IDX_CFG * 4);
  localparam logic [ADDR_W-1:0] ADDR_STATUS    = ADDR_W'(IDX_STATUS * 4);

  // field positions
  localparam int PD_LSB        = 4;
  localparam int THR_MODE_BIT  = 7;
  localparam int THR_COMB_BIT  = 6;
  localparam int CFG_RST_BIT   = 7;
  localparam int CFG_MUX_LSB   = 4;
  localparam int CFG_CNTEN_BIT = 3;
  localparam int CFG_SEL_LSB   = 0;
  localparam int ST_WATCH_BIT  = 0;
  localparam int ST_QUAL_LSB   = 1;
  localparam int ST_WAKE_BIT   = 4;

  // shadow selector codes; 3'h0 and 3'h4 select nothing
  localparam logic [2:0] SEL_THR_X = 3'h1;
  localparam logic [2:0] SEL_CNT_X = 3'h5;

  // reset values and field maxima
  localparam logic [2:0]       RST_PD    = 3'h0;
  localparam logic [2:0]       RST_SEL   = 3'h0;
  localparam logic [2:0]       RST_MUX   = 3'h0;
  localparam logic [FLD_W-1:0] RST_FIELD = 6'h00;
  localparam logic [FLD_W-1:0] FLD_MAX   = 6'h3f;
  localparam logic [DELTA_W-1:0] DELTA_MAX = 11'h7ff;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== hw/mwd_axis_detect.sv ====
// one axis of the motion wake detector: delta, window, threshold, counter
// assumes samples arrive on the same clock with a one-cycle valid strobe
`timescale 1ns/1ps
module mwd_axis_detect
  import mwd_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic             sampleValid,
  input  wire logic [SMP_W-1:0] sampleIn,
  input  wire logic             watchOn,
  input  wire logic             clearPulse,
  input  wire logic             baselineMode,
  input  wire logic [2:0]       windowSel,
  input  wire logic [FLD_W-1:0] threshold,
  input  wire logic [FLD_W-1:0] eventCount,
  input  wire logic             countEnable,
  output logic                  hitPulse,
  output logic                  qualified
);

  logic             refValid_ff;
  logic [SMP_W-1:0] ref_ff;
  logic [FLD_W-1:0] hitCnt_ff;
  logic             hit_ff;
  logic             qual_ff;
  logic [SMP_W:0]   diff;
  logic [SMP_W:0]   absDiff;
  logic [DELTA_W-1:0] delta;
  logic [DELTA_W-1:0] shifted;
  logic             over;
  logic             take;

  // delta = reference minus current, magnitude clamped to 11 bits
  always_comb begin
    diff    = {ref_ff[SMP_W-1], ref_ff} - {sampleIn[SMP_W-1], sampleIn};
    absDiff = diff[SMP_W] ? (~diff + 1'b1) : diff;
    delta   = (absDiff > {2'b00, DELTA_MAX}) ? DELTA_MAX
                                             : absDiff[DELTA_W-1:0];
    shifted = delta >> windowSel;
    // bits above the window count as exceeding it, so no event is lost
    over = (|shifted[DELTA_W-1:FLD_W]) ||
           (shifted[FLD_W-1:0] > threshold);
  end

  assign take = clkEn && watchOn && sampleValid && !clearPulse;

  // reference: previous sample, or first sample held as baseline
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      refValid_ff <= 1'b0;
      ref_ff      <= '0;
    end else if (clkEn && clearPulse) begin
      refValid_ff <= 1'b0;
    end else if (take) begin
      refValid_ff <= 1'b1;
      if (!refValid_ff || !baselineMode) begin
        ref_ff <= sampleIn;
      end
    end
  end

  // hit counter saturates so a long burst never wraps to zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hitCnt_ff <= RST_FIELD;
      hit_ff    <= 1'b0;
      qual_ff   <= 1'b0;
    end else if (clkEn) begin
      hit_ff <= take && refValid_ff && over;
      if (clearPulse) begin
        hitCnt_ff <= RST_FIELD;
        qual_ff   <= 1'b0;
      end else if (take && refValid_ff && over) begin
        if (hitCnt_ff != FLD_MAX) begin
          hitCnt_ff <= hitCnt_ff + 1'b1;
        end
        if (!countEnable || hitCnt_ff >= eventCount) begin
          qual_ff <= 1'b1;
        end
      end
    end
  end

  assign hitPulse  = hit_ff;
  assign qualified = qual_ff;

endmodule

// ==== hw/mwd_motion_wake_top.sv ====
// motion wake detector: register file, three axis slices, wake combine
// assumes an AXI4-Lite master and samples on the same 10 MHz clock
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
module mwd_motion_wake_top
  import mwd_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [DATA_W-1:0]      rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              sampleValid,
  input  wire logic [SMP_W-1:0]  sampleX,
  input  wire logic [SMP_W-1:0]  sampleY,
  input  wire logic [SMP_W-1:0]  sampleZ,
  input  wire logic              watchMode,
  output logic                   wakeLevel,
  output logic                   wakeEvent
);

  // register map, byte addresses four times the printed index:
  //   axis control      bits 6:4 power down x, y, z (1 leaves the axis out)
  //   threshold control bit 7 delta method, bit 6 combine, bits 5:0 shadow
  //   configuration     bit 7 counter reset (reads 0), bits 6:4 window,
  //                     bit 3 count enable, bits 2:0 shadow selector
  //   status            bit 0 watch, bits 3:1 qualified x..z, bit 4 wake
  //   any other address answers slave error and has no effect
  // status is read only; its writes are accepted and ignored
  // data sits in byte lane 0; a write with wstrb[0] low changes nothing
  // but still answers okay, so a master that probes lanes sees no error
  //
  // timing from watch entry: the clear pulse lands one edge later, the
  // first sample after it only loads the reference, the next one can hit,
  // and the wake level and event follow one edge after qualification
  // with counting enabled, an axis needs count plus one hits, which need
  // not be consecutive; the hit counter stops at its top rather than wrap
  //
  // software-visible control state
  logic [2:0]       axisPd_ff;
  logic             deltaMethod_ff;
  logic             combineAnd_ff;
  logic [2:0]       shadowSel_ff;
  logic             countEn_ff;
  logic [2:0]       windowSel_ff;
  logic [FLD_W-1:0] thrField_ff [AXIS_N];
  logic [FLD_W-1:0] cntField_ff [AXIS_N];

  // bus response state
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [DATA_W-1:0] rdata_ff;

  // watch and wake state
  logic              watchPrev_ff;
  logic              clear_ff;
  logic              wake_ff;
  logic              wakeEvent_ff;

  logic              wrFire;
  logic              rdFire;
  logic              wrLane0;
  logic              rstRequest;
  logic [SMP_W-1:0]  sampleArr [AXIS_N];
  logic [AXIS_N-1:0] qualVec;
  logic [AXIS_N-1:0] hitVec;
  logic [AXIS_N-1:0] activeVec;
  logic              anyWake;
  logic              allWake;
  logic              nxt_wake;
  logic [FLD_W-1:0]  shadowRead;
  logic [DATA_W-1:0] nxt_rdata;
  logic [1:0]        nxt_rresp;

  // the bus side is a single-beat slave: address and data must arrive
  // together, and a response must be retired before the next is taken;
  // this costs a cycle per access but needs no holding registers for a
  // lone address or lone data beat
  // a write is taken only with address and data both present and no
  // response pending; clock enable gates the handshake so nothing slips
  // through while state is frozen
  assign wrFire  = clkEn && awvalid && wvalid && !bvalid_ff;
  assign awready = wrFire;
  assign wready  = wrFire;
  assign rdFire  = clkEn && arvalid && !rvalid_ff;
  assign arready = rdFire;
  assign wrLane0 = wstrb[0];

  assign bvalid = bvalid_ff;
  assign bresp  = bresp_ff;
  assign rvalid = rvalid_ff;
  assign rresp  = rresp_ff;
  assign rdata  = rdata_ff;

  // self-clearing counter reset through the configuration register
  assign rstRequest = wrFire && wrLane0 && (awaddr == ADDR_CFG) &&
                      wdata[CFG_RST_BIT];

  // axis control: only the power-down field is kept
  // the other fields of that register belong to rate logic outside here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      axisPd_ff <= RST_PD;
    end else if (wrFire && wrLane0 && awaddr == ADDR_AXIS_CTRL) begin
      axisPd_ff <= wdata[PD_LSB +: 3];
    end
  end

  // threshold control: mode bits stored here, low bits go to shadows
  // the low six bits of the same write go to the shadow fields below
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      deltaMethod_ff <= 1'b0;
      combineAnd_ff  <= 1'b0;
    end else if (wrFire && wrLane0 && awaddr == ADDR_THR_CTRL) begin
      deltaMethod_ff <= wdata[THR_MODE_BIT];
      combineAnd_ff  <= wdata[THR_COMB_BIT];
    end
  end

  // configuration: selector, count enable and window select
  // the reset bit is not stored; it only raises the clear pulse below
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shadowSel_ff <= RST_SEL;
      countEn_ff   <= 1'b0;
      windowSel_ff <= RST_MUX;
    end else if (wrFire && wrLane0 && awaddr == ADDR_CFG) begin
      shadowSel_ff <= wdata[CFG_SEL_LSB +: 3];
      countEn_ff   <= wdata[CFG_CNTEN_BIT];
      windowSel_ff <= wdata[CFG_MUX_LSB +: 3];
    end
  end

  // an array of samples lets the generate loop index the axes
  assign sampleArr[0] = sampleX;
  assign sampleArr[1] = sampleY;
  assign sampleArr[2] = sampleZ;

  // per-axis shadow storage and detector slice
  for (genvar a = 0; a < AXIS_N; a++) begin : gAxis
    localparam logic [2:0] SelThr = SEL_THR_X + 3'(a);
    localparam logic [2:0] SelCnt = SEL_CNT_X + 3'(a);

    // shadow write lands only in the field the selector points at
    // a write with selector 0 or 4 matches no field and is dropped
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        thrField_ff[a] <= RST_FIELD;
        cntField_ff[a] <= RST_FIELD;
      end else if (wrFire && wrLane0 && awaddr == ADDR_THR_CTRL) begin
        if (shadowSel_ff == SelThr) begin
          thrField_ff[a] <= wdata[FLD_W-1:0];
        end
        if (shadowSel_ff == SelCnt) begin
          cntField_ff[a] <= wdata[FLD_W-1:0];
        end
      end
    end

    // every slice shares mode, window and enable; only limits differ
    mwd_axis_detect uDetect (
      .clock        (clock),
      .rst_n        (rst_n),
      .clkEn        (clkEn),
      .sampleValid  (sampleValid),
      .sampleIn     (sampleArr[a]),
      .watchOn      (watchMode),
      .clearPulse   (clear_ff),
      .baselineMode (deltaMethod_ff),
      .windowSel    (windowSel_ff),
      .threshold    (thrField_ff[a]),
      .eventCount   (cntField_ff[a]),
      .countEnable  (countEn_ff),
      .hitPulse     (hitVec[a]),
      .qualified    (qualVec[a])
    );
  end

  // watch entry or a software reset clears references and counters;
  // registered so the slices see one clean cycle of clear
  // a reset-bit write and a watch entry in one cycle give one clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchPrev_ff <= 1'b0;
      clear_ff     <= 1'b0;
    end else if (clkEn) begin
      watchPrev_ff <= watchMode;
      clear_ff     <= (watchMode && !watchPrev_ff) || rstRequest;
    end
  end

  // combine only axes that are not powered down; with none active the
  // and-mode never fires, since there is nothing to agree
  // the or-mode ignores powered-down axes because their qualified bits
  // are masked; the and-mode treats them as agreeing, so removing an
  // axis never blocks the others
  always_comb begin
    activeVec = ~axisPd_ff;
    anyWake   = |(qualVec & activeVec);
    allWake   = (&(qualVec | ~activeVec)) && (|activeVec);
    nxt_wake  = watchMode && (combineAnd_ff ? allWake : anyWake);
  end

  // wake level is sticky until the next clear; event is one cycle
  // a level plus a pulse lets polling software and edge logic share it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wake_ff      <= 1'b0;
      wakeEvent_ff <= 1'b0;
    end else if (clkEn) begin
      if (clear_ff) begin
        wake_ff      <= 1'b0;
        wakeEvent_ff <= 1'b0;
      end else begin
        wake_ff      <= wake_ff || nxt_wake;
        wakeEvent_ff <= nxt_wake && !wake_ff;
      end
    end
  end

  assign wakeLevel = wake_ff;
  assign wakeEvent = wakeEvent_ff;

  // write response: unmapped addresses answer slave error
  // every mapped offset answers okay, status too, though its writes drop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (clkEn) begin
      if (wrFire) begin
        bvalid_ff <= 1'b1;
        if (awaddr == ADDR_AXIS_CTRL) begin
          bresp_ff <= RESP_OKAY;
        end else if (awaddr == ADDR_THR_CTRL) begin
          bresp_ff <= RESP_OKAY;
        end else if (awaddr == ADDR_CFG) begin
          bresp_ff <= RESP_OKAY;
        end else if (awaddr == ADDR_STATUS) begin
          bresp_ff <= RESP_OKAY;
        end else begin
          bresp_ff <= RESP_SLVERR;
        end
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // shadow readback follows the selector; none reads as zero
  always_comb begin
    shadowRead = RST_FIELD;
    for (int i = 0; i < AXIS_N; i++) begin
      if (shadowSel_ff == SEL_THR_X + 3'(i)) begin
        shadowRead = thrField_ff[i];
      end
      if (shadowSel_ff == SEL_CNT_X + 3'(i)) begin
        shadowRead = cntField_ff[i];
      end
    end
  end

  // read decode; reserved bits and the reset bit read as zero
  // unmapped reads return zero data along with the slave error
  always_comb begin
    nxt_rdata = '0;
    nxt_rresp = RESP_OKAY;
    if (araddr == ADDR_AXIS_CTRL) begin
      nxt_rdata[PD_LSB +: 3] = axisPd_ff;
    end else if (araddr == ADDR_THR_CTRL) begin
      nxt_rdata[THR_MODE_BIT] = deltaMethod_ff;
      nxt_rdata[THR_COMB_BIT] = combineAnd_ff;
      nxt_rdata[FLD_W-1:0]    = shadowRead;
    end else if (araddr == ADDR_CFG) begin
      nxt_rdata[CFG_SEL_LSB +: 3] = shadowSel_ff;
      nxt_rdata[CFG_CNTEN_BIT]    = countEn_ff;
      nxt_rdata[CFG_MUX_LSB +: 3] = windowSel_ff;
    end else if (araddr == ADDR_STATUS) begin
      nxt_rdata[ST_WATCH_BIT]      = watchMode;
      nxt_rdata[ST_QUAL_LSB +: 3]  = qualVec;
      nxt_rdata[ST_WAKE_BIT]       = wake_ff;
    end else begin
      nxt_rresp = RESP_SLVERR;
    end
  end

  // read data is captured at the address handshake and held until taken
  // capturing there keeps rdata stable if status moves while the master
  // is slow to raise rready
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= '0;
    end else if (clkEn) begin
      if (rdFire) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= nxt_rresp;
        rdata_ff  <= nxt_rdata;
      end else if (rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

endmodule

// ==== sim/mwd_motion_wake_chk.sv ====
// checker for the motion wake detector top: bus handshakes and wake output
// assumes it is bound to mwd_motion_wake_top and sees only its ports
`timescale 1ns/1ps
module mwd_motion_wake_chk
  import mwd_pkg::*;
(
  input wire logic              clock,
  input wire logic              rst_n,
  input wire logic              clkEn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              watchMode,
  input wire logic              wakeLevel,
  input wire logic              wakeEvent
);
  default clocking chkClk @(posedge clock); endclocking
  default disable iff (!rst_n);

  // handshake readiness ties to the valids and the pending response
  aw_ready_a: assert property (awready == (clkEn && awvalid && wvalid && !bvalid))
    else $error("write ready wrong");
  w_ready_a: assert property (wready == awready)
    else $error("write data ready differs from address ready");
  ar_ready_a: assert property (arready == (clkEn && arvalid && !rvalid))
    else $error("read ready wrong");
  b_answer_a: assert property (awready |=> bvalid)
    else $error("write response missing");
  b_hold_a: assert property (bvalid && !(bready && clkEn) |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  r_answer_a: assert property (arready |=> rvalid)
    else $error("read response missing");
  r_hold_a: assert property (rvalid && !(rready && clkEn) |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");

  // wake pulse marks exactly the rise of the sticky wake level
  wake_event_a: assert property (wakeEvent == $rose(wakeLevel))
    else $error("wake pulse not at wake rise");
  wake_single_a: assert property (wakeEvent |=> !wakeEvent)
    else $error("wake pulse longer than one cycle");
  wake_watch_a: assert property ($rose(wakeLevel) |-> $past(watchMode))
    else $error("wake rose outside watch mode");
  wake_clear_a: assert property ($rose(watchMode) |-> ##[1:3] !wakeLevel)
    else $error("wake not cleared on watch entry");

  cover property ($rose(wakeLevel));
  cover property (bvalid && bresp == RESP_SLVERR);
  cover property (rvalid && rready);
endmodule

bind mwd_motion_wake_top mwd_motion_wake_chk chk (
  .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .watchMode(watchMode), .wakeLevel(wakeLevel), .wakeEvent(wakeEvent)
);

// ==== sim/motion_wake_threshold_detector_bench.sv ====
// self-checking bench for the motion wake detector top
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ps
module motion_wake_threshold_detector_bench
  import mwd_pkg::*;
  ;
  logic              clock = 1'h0;
  logic              rst_n = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic              arvalid = 1'h0, rready = 1'h0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic              sampleValid = 1'h0, watchMode = 1'h0;
  logic              wakeLevel, wakeEvent;
  logic [SMP_W-1:0]  sampleX = '0, sampleY = '0, sampleZ = '0;
  logic [2:0]        win = 3'h0;
  logic              cen = 1'h0, md = 1'h0, cb = 1'h0;
  logic              clkEn = 1'h1;
  int                fails = 0, compares = 0, evCnt = 0, ev0 = 0, cyc = 0;
  logic [7:0]        regs [4] = '{ADDR_AXIS_CTRL, ADDR_THR_CTRL, ADDR_CFG,
                                  ADDR_STATUS};
  logic [5:0]        shv [8] = '{6'h11, 6'h3f, 6'h00, 6'h2a, 6'h11, 6'h3d,
                                 6'h01, 6'h15};

  // protection carries nothing this block uses; strobes are tied all on, since wstrb[0] gates writes
  mwd_motion_wake_top DUT (
    .clock(clock), .rst_n(rst_n), .clkEn(clkEn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sampleValid(sampleValid),
    .sampleX(sampleX), .sampleY(sampleY), .sampleZ(sampleZ),
    .watchMode(watchMode), .wakeLevel(wakeLevel), .wakeEvent(wakeEvent)
  );

  always #50 clock = ~clock;

  // wake pulses counted here; the cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (wakeEvent === 1'h1) evCnt <= evCnt + 1;
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ready is looked at on the falling edge, so the taking edge is certain
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    do @(negedge clock); while (awready !== 1'h1);
    @(posedge clock);
    awvalid <= 1'h0;
    wvalid  <= 1'h0;
    bready  <= 1'h1;
    do @(negedge clock); while (bvalid !== 1'h1);
    chk(32'(bresp), 32'(er));
    @(posedge clock);
    bready  <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ed,
                    input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(negedge clock); while (arready !== 1'h1);
    @(posedge clock);
    arvalid <= 1'h0;
    rready  <= 1'h1;
    do @(negedge clock); while (rvalid !== 1'h1);
    chk(rdata, {24'h0, ed});
    chk(32'(rresp), 32'(er));
    @(posedge clock);
    rready  <= 1'h0;
  endtask

  // same threshold on all axes, same count on all axes
  task automatic setAll(input logic [5:0] t, input logic [5:0] c);
    for (int s = 1; s < 8; s++) begin
      if (s == 4) continue;
      wr(ADDR_CFG, {1'h0, win, cen, 3'(s)}, RESP_OKAY);
      wr(ADDR_THR_CTRL, {md, cb, (s < 4) ? t : c}, RESP_OKAY);
    end
  endtask

  task automatic smp(input int x, input int yz);
    sampleX     <= SMP_W'(x);
    sampleY     <= SMP_W'(yz);
    sampleZ     <= SMP_W'(yz);
    sampleValid <= 1'h1;
    @(posedge clock);
    sampleValid <= 1'h0;
    repeat (3) @(posedge clock);
  endtask

  task automatic enter();
    watchMode <= 1'h0;
    repeat (2) @(posedge clock);
    watchMode <= 1'h1;
    repeat (3) @(posedge clock);
    ev0 = evCnt;
  endtask

  task automatic wake(input logic e);
    @(negedge clock);
    chk(32'(wakeLevel), 32'(e));
    chk(32'(evCnt - ev0), 32'(e));
    @(posedge clock);
  endtask

  task automatic run2(input int x0, input int x1, input int yz, input logic e);
    enter();
    smp(x0, 0);
    smp(x1, yz);
    wake(e);
  endtask

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'h1;
    @(posedge clock);
    foreach (regs[i]) rd(regs[i], 8'h00, RESP_OKAY);
    // every selector code, the two empty ones included
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CFG, {5'h0, 3'(s)}, RESP_OKAY);
      wr(ADDR_THR_CTRL, {2'h0, shv[s]}, RESP_OKAY);
    end
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CFG, {5'h0, 3'(s)}, RESP_OKAY);
      rd(ADDR_THR_CTRL, (s % 4 == 0) ? 8'h00 : {2'h0, shv[s]}, RESP_OKAY);
    end
    wr(ADDR_STATUS, 8'hff, RESP_OKAY);
    rd(ADDR_STATUS, 8'h00, RESP_OKAY);
    wr(8'h08, 8'h5a, RESP_SLVERR);
    rd(8'h08, 8'h00, RESP_SLVERR);
    wr(8'h41, 8'h70, RESP_SLVERR);
    rd(ADDR_AXIS_CTRL, 8'h00, RESP_OKAY);
    // strict comparison, then counter reset through the config register
    cen = 1'h1;
    setAll(6'h0a, 6'h00);
    run2(100, 110, 0, 1'h0);
    smp(121, 0);
    wake(1'h1);
    rd(ADDR_STATUS, 8'h13, RESP_OKAY);
    wr(ADDR_CFG, 8'h88, RESP_OKAY);
    rd(ADDR_CFG, 8'h08, RESP_OKAY);
    ev0 = evCnt;
    wake(1'h0);
    // slow drift only trips the baseline method
    for (int m = 0; m < 2; m++) begin
      md = 1'(m);
      setAll(6'h0a, 6'h00);
      enter();
      for (int i = 0; i < 3; i++) smp(100 + 6 * i, 0);
      wake(1'(m));
    end
    md = 1'h0;
    setAll(6'h0a, 6'h02);
    enter();
    for (int i = 0; i < 3; i++) smp(20 * (i % 2), 0);
    wake(1'h0);
    smp(20, 0);
    wake(1'h1);
    cen = 1'h0;
    setAll(6'h0a, 6'h02);
    run2(0, 20, 0, 1'h1);
    cen = 1'h1;
    cb = 1'h1;
    setAll(6'h0a, 6'h00);
    run2(0, 20, 0, 1'h0);
    smp(40, 20);
    wake(1'h1);
    wr(ADDR_AXIS_CTRL, 8'h60, RESP_OKAY);
    run2(0, 20, 0, 1'h1);
    cb = 1'h0;
    setAll(6'h0a, 6'h00);
    wr(ADDR_AXIS_CTRL, 8'h10, RESP_OKAY);
    rd(ADDR_AXIS_CTRL, 8'h10, RESP_OKAY);
    run2(0, 20, 0, 1'h0);
    wr(ADDR_AXIS_CTRL, 8'h00, RESP_OKAY);
    // window shift, then deltas above the window counting as exceeding it
    win = 3'h1;
    setAll(6'h0a, 6'h00);
    run2(0, 21, 0, 1'h0);
    smp(43, 0);
    wake(1'h1);
    win = 3'h0;
    setAll(6'h3f, 6'h00);
    run2(0, 63, 0, 1'h0);
    smp(263, 0);
    wake(1'h1);
    // a low clock enable must swallow a sample that would otherwise hit
    enter();
    smp(0, 0);
    clkEn <= 1'h0;
    smp(300, 0);
    clkEn <= 1'h1;
    @(posedge clock);
    wake(1'h0);
    smp(300, 0);
    wake(1'h1);
    test_done();
  end
endmodule
